// [logic/scc_claim.sv]
// Purpose: claim decision for configuration commands seen on a secondary bus
// Assumes: secondary bus pins sampled on sys_clk; primary side runs claimed cycles
// Notes:   holds both configuration header sets; SEC_SET picks this port's set
`default_nettype none

// Overview of operation
// - a type 0 configuration write on the secondary bus is ignored and never claimed.
// - a type 1 configuration write is ignored unless it encodes a special cycle request.
// - a configuration write with device 1Fh and function 7h is a special cycle request.
// - a special cycle request for the primary bus number is claimed and run there as a special cycle.
// - a request for a bus that is neither primary nor in secondary..subordinate is claimed and forwarded unchanged as type 1.
// - a request for a non-primary bus inside secondary..subordinate is ignored.
// - two nearly identical configuration sets exist, each reached by its own function number.
// - each set holds a 64-byte bridge configuration header.
// - the first set serves secondary bus 1 and the second set serves secondary bus 2.
// - settings of the primary interface are kept in the first set only.
// - a special cycle command seen on the secondary bus is ignored and never claimed.
module scc_claim
	import scc_pkg::*;
#(
	parameter bit          SEC_SET = 1'b0,         // 0: secondary bus 1, 1: bus 2
	parameter logic [15:0] VEN_ID  = 16'h0abc,     // arbitrary value
	parameter logic [15:0] DEV_ID  = 16'h0123,     // arbitrary value
	parameter logic [31:0] CLASS   = 32'h0604_0000 // class code and revision
)
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// secondary bus pins
	input  wire logic        s_frame_n,
	input  wire logic [31:0] s_ad,
	input  wire logic [3:0]  s_cbe_n,
	// configuration access port
	input  wire logic        cfg_we,
	input  wire logic        cfg_re,
	input  wire logic [2:0]  cfg_func,
	input  wire logic [3:0]  cfg_dw,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic [31:0]      cfg_rdata,
	output logic             cfg_rvalid,
	output logic             cfg_miss,
	// claim and forwarding requests
	output logic             claim,
	output logic             fwd_special,
	output logic             fwd_type1,
	output logic [31:0]      fwd_addr
);

	// ------------------------------------------------------------------
	// functions
	// ------------------------------------------------------------------
	function automatic logic in_range(input logic [7:0] bus, input logic [7:0] lo,
		input logic [7:0] hi);
		in_range = (bus >= lo) && (bus <= hi);
	endfunction

	// lanes software may not write in a given set and dword
	function automatic logic [3:0] ro_lanes(input logic set, input logic [3:0] dw);
		ro_lanes = LANES_NONE;
		if (dw == DW_ID || dw == DW_CLASS)
			ro_lanes = LANES_ALL;
		else if (dw == DW_HDR)
			ro_lanes = set ? (RO_HDR | PRI_HDR) : RO_HDR;
		else if (dw == DW_BUSNUM && set)
			ro_lanes = PRI_BUSN;
	endfunction

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic        frame_q1;
	logic        frame_q2;
	logic        frame_q3;
	logic [31:0] ad_q1;
	logic [31:0] ad_q2;
	logic [3:0]  cbe_q1;
	logic [3:0]  cbe_q2;

	// two stages for every pin, third stage of frame for edge detect
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			frame_q1 <= 1'b1;
			frame_q2 <= 1'b1;
			frame_q3 <= 1'b1;
			ad_q1    <= 32'h0000_0000;
			ad_q2    <= 32'h0000_0000;
			cbe_q1   <= 4'hf;
			cbe_q2   <= 4'hf;
		end
		else
		begin
			frame_q1 <= s_frame_n;
			frame_q2 <= frame_q1;
			frame_q3 <= frame_q2;
			ad_q1    <= s_ad;
			ad_q2    <= ad_q1;
			cbe_q1   <= s_cbe_n;
			cbe_q2   <= cbe_q1;
		end
	end

	// ------------------------------------------------------------------
	// configuration header storage
	// ------------------------------------------------------------------
	// 64-byte header
	logic [31:0] hdr_mem [2][HDR_DWORDS];
	logic [3:0]  wr_lanes;
	logic        set_sel;
	logic        set_ok;

	assign set_ok   = (cfg_func == FN_SET1) || (cfg_func == FN_SET2);
	assign set_sel  = (cfg_func == FN_SET2);
	assign wr_lanes = cfg_be & ~ro_lanes(set_sel, cfg_dw);

	// byte-lane writes, read-only lanes keep their reset image
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			for (int s = 0; s < 2; s++)
			begin
				for (int d = 0; d < HDR_DWORDS; d++)
				begin
					hdr_mem[s][d] <= (d == int'(DW_HDR)) ? RST_HDR : RST_DWORD;
				end
			end
		end
		else if (cfg_we && set_ok)
		begin
			for (int b = 0; b < 4; b++)
			begin
				if (wr_lanes[b])
					hdr_mem[set_sel][cfg_dw][8*b +: 8] <= cfg_wdata[8*b +: 8];
			end
		end
	end

	// read view of the selected set
	logic [31:0] next_rdata;

	always_comb
	begin
		next_rdata = RST_DWORD;
		if (set_ok)
		begin
			next_rdata = hdr_mem[set_sel][cfg_dw];
			if (cfg_dw == DW_ID)
				next_rdata = {DEV_ID, VEN_ID};
			else if (cfg_dw == DW_CLASS)
				next_rdata = CLASS;
			// primary settings come from the first set
			else if (set_sel && cfg_dw == DW_HDR)
				next_rdata[15:8] = hdr_mem[0][DW_HDR][15:8];
			else if (set_sel && cfg_dw == DW_BUSNUM)
				next_rdata[7:0] = hdr_mem[0][DW_BUSNUM][7:0];
		end
	end

	// registered read answer, unmapped functions read zero
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			cfg_rdata  <= RST_DWORD;
			cfg_rvalid <= 1'b0;
			cfg_miss   <= 1'b0;
		end
		else
		begin
			cfg_rvalid <= cfg_re;
			cfg_miss   <= cfg_re && !set_ok;
			if (cfg_re)
				cfg_rdata <= next_rdata;
		end
	end

	// ------------------------------------------------------------------
	// address phase decode
	// ------------------------------------------------------------------
	logic       addr_phase;
	logic [7:0] t_bus;
	logic [7:0] pri_bus;
	logic [7:0] sec_bus;
	logic [7:0] sub_bus;
	logic       is_cfg_wr;
	logic       is_type1;
	logic       spec_req;
	scc_act_t   next_act;

	assign addr_phase = frame_q3 && !frame_q2; // first cycle with frame low
	assign is_cfg_wr = (cbe_q2 == CMD_CFG_WR);
	assign is_type1  = (ad_q2[1:0] == CFG_TYPE1);
	assign t_bus     = ad_q2[AD_BUS_LSB +: 8];
	assign spec_req  = is_cfg_wr && is_type1
		&& (ad_q2[AD_DEV_LSB +: 5] == DEV_SPECIAL)
		&& (ad_q2[AD_FUNC_LSB +: 3] == FUNC_SPECIAL);
	// this port's bus range from its own set
	assign sec_bus   = hdr_mem[SEC_SET][DW_BUSNUM][BN_SEC_LSB +: 8];
	assign sub_bus   = hdr_mem[SEC_SET][DW_BUSNUM][BN_SUB_LSB +: 8];
	// primary bus number only in the first set
	assign pri_bus   = hdr_mem[0][DW_BUSNUM][BN_PRI_LSB +: 8];

	// outcome of one command; special cycle and other commands fall to ignore
	always_comb
	begin
		next_act = ACT_IGNORE;
		// type 0 and plain type 1 stay ignored
		if (spec_req)
		begin
			if (t_bus == pri_bus)
				next_act = ACT_SPECIAL;
			// outside the range goes on as type 1
			else if (!in_range(t_bus, sec_bus, sub_bus))
				next_act = ACT_TYPE1;
			else
				next_act = ACT_IGNORE;
		end
	end

	// ------------------------------------------------------------------
	// claim and forward pulses
	// ------------------------------------------------------------------
	// one-cycle pulses the cycle after the address phase
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			claim       <= 1'b0;
			fwd_special <= 1'b0;
			fwd_type1   <= 1'b0;
		end
		else
		begin
			// special cycle command never reaches a claim
			claim       <= addr_phase && (next_act != ACT_IGNORE);
			fwd_special <= addr_phase && (next_act == ACT_SPECIAL);
			fwd_type1   <= addr_phase && (next_act == ACT_TYPE1);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			fwd_addr <= 32'h0000_0000;
		else if (addr_phase && next_act != ACT_IGNORE)
			fwd_addr <= ad_q2;
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	a_type0_ignored: assert property (
		addr_phase && is_cfg_wr && ad_q2[1:0] == CFG_TYPE0 |=> !claim)
		else $error("type 0 configuration write claimed");
	a_type1_plain: assert property (
		addr_phase && is_cfg_wr && is_type1 && !spec_req |=> !claim && !fwd_type1)
		else $error("plain type 1 write claimed");
	a_claim_needs_spec: assert property (
		claim |-> $past(spec_req) && $past(addr_phase))
		else $error("claim without special cycle request");
	a_pri_special: assert property (
		addr_phase && spec_req && t_bus == pri_bus
		|=> claim && fwd_special && !fwd_type1 ##1 !claim)
		else $error("primary special request not run as special cycle");
	a_fwd_unchanged: assert property (
		addr_phase && spec_req && t_bus != pri_bus && !in_range(t_bus, sec_bus, sub_bus)
		|=> fwd_type1 && claim && fwd_addr == $past(ad_q2))
		else $error("out of range request not forwarded unchanged");
	a_in_range_ignored: assert property (
		addr_phase && spec_req && t_bus != pri_bus && in_range(t_bus, sec_bus, sub_bus)
		|=> !claim && $stable(fwd_addr))
		else $error("in range request claimed");
	a_special_cmd: assert property (
		addr_phase && cbe_q2 == CMD_SPECIAL |=> !claim)
		else $error("special cycle command claimed");
	a_func_miss: assert property (
		cfg_re && !set_ok |=> cfg_rvalid && cfg_miss && cfg_rdata == RST_DWORD)
		else $error("unmapped function answered with data");
	a_set2_primary: assert property (
		cfg_re && cfg_func == FN_SET2 && cfg_dw == DW_BUSNUM
		|=> cfg_rdata[7:0] == $past(hdr_mem[0][DW_BUSNUM][7:0]))
		else $error("second set shows its own primary bus number");

	c_special: cover property (fwd_special);
	c_type1: cover property (fwd_type1 ##1 !claim);
	c_ignored: cover property (addr_phase && spec_req && next_act == ACT_IGNORE);

endmodule // scc_claim

`default_nettype wire

// [logic/scc_pkg.sv]
// Purpose: constants for the secondary-side configuration cycle claim logic
// Assumes: PCI command codes as seen on the C/BE# lines in the address phase
// Notes:   offsets, field positions and reset values live here only
`default_nettype none

package scc_pkg;
	// ------------------------------------------------------------------
	// bus commands (raw C/BE# value)
	// ------------------------------------------------------------------
	localparam logic [3:0] CMD_SPECIAL = 4'h1;
	localparam logic [3:0] CMD_CFG_WR  = 4'hb;

	// ------------------------------------------------------------------
	// configuration address fields
	// ------------------------------------------------------------------
	localparam logic [1:0] CFG_TYPE0    = 2'h0;
	localparam logic [1:0] CFG_TYPE1    = 2'h1;
	localparam int         AD_BUS_LSB   = 16;
	localparam int         AD_DEV_LSB   = 11;
	localparam int         AD_FUNC_LSB  = 8;
	localparam logic [4:0] DEV_SPECIAL  = 5'h1f;
	localparam logic [2:0] FUNC_SPECIAL = 3'h7;

	// ------------------------------------------------------------------
	// configuration header layout
	// ------------------------------------------------------------------
	localparam int         HDR_BYTES  = 64;
	localparam int         HDR_DWORDS = HDR_BYTES / 4;
	localparam logic [3:0] DW_ID      = 4'h0;
	localparam logic [3:0] DW_CLASS   = 4'h2;
	localparam logic [3:0] DW_HDR     = 4'h3;
	localparam logic [3:0] DW_BUSNUM  = 4'h6;
	localparam int         BN_PRI_LSB = 0;
	localparam int         BN_SEC_LSB = 8;
	localparam int         BN_SUB_LSB = 16;
	localparam logic [2:0] FN_SET1    = 3'h0;
	localparam logic [2:0] FN_SET2    = 3'h1;

	// ------------------------------------------------------------------
	// values after reset and lane masks
	// ------------------------------------------------------------------
	localparam logic [31:0] RST_DWORD = 32'h0000_0000;
	localparam logic [31:0] RST_HDR   = 32'h0001_0000;
	localparam logic [3:0]  RO_HDR    = 4'h4;
	localparam logic [3:0]  PRI_HDR   = 4'h2;
	localparam logic [3:0]  PRI_BUSN  = 4'h1;
	localparam logic [3:0]  LANES_ALL = 4'hf;
	localparam logic [3:0]  LANES_NONE = 4'h0;

	// decode outcome of one address phase
	typedef enum logic [1:0] {
		ACT_IGNORE,
		ACT_SPECIAL,
		ACT_TYPE1
	} scc_act_t;
endpackage

`default_nettype wire

// [sim/scc_init_model.sv]
// Purpose: secondary bus initiator model for the claim bench
// Assumes: one address phase per request; data phases are not modelled
// Notes:   AD and C/BE# invert every idle cycle; FRAME# idles high (pull-up)
`default_nettype none

module scc_init_model
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// request from the bench
	input  wire logic        go,
	input  wire logic [3:0]  cmd,
	input  wire logic [31:0] addr,
	// secondary bus pins
	output logic             s_frame_n,
	output logic [31:0]      s_ad,
	output logic [3:0]       s_cbe_n
);
	timeunit 1ns;
	timeprecision 1ps;

	// frame low for one address phase, then released with AD churning
	// command on C/BE#, target on AD
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			s_frame_n <= 1'b1;
			s_ad      <= 32'h5a5a_a5a5;
			s_cbe_n   <= 4'h5;
		end
		else if (go)
		begin
			s_frame_n <= 1'b0;
			s_ad      <= addr;
			s_cbe_n   <= cmd;
		end
		else
		begin
			s_frame_n <= 1'b1;
			s_ad      <= ~s_ad;
			s_cbe_n   <= ~s_cbe_n;
		end
	end
endmodule // scc_init_model

`default_nettype wire

// [sim/scc_claim_tb.sv]
// Purpose: self-checking bench for the secondary configuration claim logic
// Assumes: set 1 bus numbers pri 01, sec 03, sub 05; this port uses set 1
// Notes:   every claim window is ten cycles after the address phase
`default_nettype none

module scc_claim_tb
	import scc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	localparam logic [15:0] T_VEN = 16'h0c1a;      // arbitrary value
	localparam logic [15:0] T_DEV = 16'h0d2b;      // arbitrary value
	localparam logic [31:0] T_CLS = 32'h0604_0001;
	localparam int          LIMIT = 3000;
	logic        sys_clk   = 1'b0;
	logic        nrst      = 1'b0;
	logic        go        = 1'b0;
	logic [3:0]  cmd       = 4'h0;
	logic [31:0] addr      = 32'h0;
	logic        cfg_we    = 1'b0;
	logic        cfg_re    = 1'b0;
	logic [2:0]  cfg_func  = 3'h0;
	logic [3:0]  cfg_dw    = 4'h0;
	logic [3:0]  cfg_be    = 4'h0;
	logic [31:0] cfg_wdata = 32'h0;
	logic        s_frame_n;
	logic [31:0] s_ad;
	logic [3:0]  s_cbe_n;
	logic [31:0] cfg_rdata;
	logic        cfg_rvalid;
	logic        cfg_miss;
	logic        claim;
	logic        fwd_special;
	logic        fwd_type1;
	logic [31:0] fwd_addr;
	int          n_errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	scc_init_model scc_init_model_inst (.sys_clk(sys_clk), .nrst(nrst), .go(go), .cmd(cmd),
		.addr(addr), .s_frame_n(s_frame_n), .s_ad(s_ad), .s_cbe_n(s_cbe_n));
	scc_claim #(.VEN_ID(T_VEN), .DEV_ID(T_DEV), .CLASS(T_CLS)) scc_claim_inst (
		.sys_clk(sys_clk), .nrst(nrst), .s_frame_n(s_frame_n), .s_ad(s_ad),
		.s_cbe_n(s_cbe_n), .cfg_we(cfg_we), .cfg_re(cfg_re), .cfg_func(cfg_func),
		.cfg_dw(cfg_dw), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cfg_rvalid(cfg_rvalid), .cfg_miss(cfg_miss), .claim(claim),
		.fwd_special(fwd_special), .fwd_type1(fwd_type1), .fwd_addr(fwd_addr));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// clock at 250 MHz
	always #2 sys_clk = ~sys_clk;

	task automatic complete_run();
		$display("errors %0d of %0d checks", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// hang guard
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			n_errors++;
			complete_run();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cfg_wr(input logic [2:0] f, input logic [3:0] d, input logic [3:0] b,
		input logic [31:0] v);
		@(posedge sys_clk);
		cfg_we    <= 1'b1;
		cfg_func  <= f;
		cfg_dw    <= d;
		cfg_be    <= b;
		cfg_wdata <= v;
		@(posedge sys_clk);
		cfg_we <= 1'b0;
	endtask

	task automatic cfg_rd(input logic [2:0] f, input logic [3:0] d, input logic [31:0] e,
		input logic m);
		@(posedge sys_clk);
		cfg_re   <= 1'b1;
		cfg_func <= f;
		cfg_dw   <= d;
		@(posedge sys_clk);
		cfg_re <= 1'b0;
		#1;
		check("cfg_rvalid", {31'h0, cfg_rvalid}, 32'h1);
		check("cfg_miss", {31'h0, cfg_miss}, {31'h0, m});
		check("cfg_rdata", cfg_rdata, e);
	endtask

	// one address phase, then count claim pulses and their kind
	task automatic bus_cyc(input logic [3:0] c, input logic [31:0] a, input scc_act_t k);
		int          ncl;
		int          nsp;
		int          nt1;
		ncl = 0;
		nsp = 0;
		nt1 = 0;
		@(posedge sys_clk);
		go   <= 1'b1;
		cmd  <= c;
		addr <= a;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (10)
		begin
			@(posedge sys_clk);
			#1;
			// anything but a clean low counts, so an unknown pulse cannot pass
			if (claim !== 1'b0)
				ncl++;
			if (fwd_special !== 1'b0)
				nsp++;
			if (fwd_type1 !== 1'b0)
				nt1++;
		end
		check("claim", ncl, (k != ACT_IGNORE) ? 1 : 0);
		check("fwd_special", nsp, (k == ACT_SPECIAL) ? 1 : 0);
		check("fwd_type1", nt1, (k == ACT_TYPE1) ? 1 : 0);
		if (k != ACT_IGNORE)
			check("fwd_addr", fwd_addr, a);
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset_vals();
		check("claim idle", {31'h0, claim}, 32'h0);
		cfg_rd(FN_SET1, DW_ID, {T_DEV, T_VEN}, 1'b0);
		cfg_wr(FN_SET1, DW_ID, LANES_ALL, 32'hffff_ffff);
		cfg_rd(FN_SET1, DW_ID, {T_DEV, T_VEN}, 1'b0);
		cfg_rd(FN_SET1, DW_CLASS, T_CLS, 1'b0);
		cfg_rd(FN_SET2, DW_HDR, 32'h0001_0000, 1'b0);
		cfg_rd(3'h2, DW_ID, 32'h0, 1'b1);
	endtask

	task automatic t_sets();
		cfg_wr(FN_SET1, DW_BUSNUM, LANES_ALL, 32'h0005_0301);
		cfg_wr(FN_SET1, DW_HDR, 4'h7, 32'h00ff_4010);
		cfg_wr(FN_SET2, DW_HDR, 4'h7, 32'h0000_2220);
		cfg_wr(FN_SET2, DW_BUSNUM, LANES_ALL, 32'h0008_06aa);
		cfg_wr(FN_SET1, 4'hf, LANES_ALL, 32'h1234_5678);
		cfg_rd(FN_SET1, DW_BUSNUM, 32'h0005_0301, 1'b0);
		cfg_rd(FN_SET1, DW_HDR, 32'h0001_4010, 1'b0);
		cfg_rd(FN_SET2, DW_HDR, 32'h0001_4020, 1'b0);
		cfg_rd(FN_SET2, DW_BUSNUM, 32'h0008_0601, 1'b0);
		cfg_rd(FN_SET1, 4'hf, 32'h1234_5678, 1'b0);
		cfg_rd(FN_SET2, 4'hf, 32'h0, 1'b0);
	endtask

	task automatic t_decode();
		bus_cyc(CMD_CFG_WR, 32'h0001_ff00, ACT_IGNORE);
		bus_cyc(CMD_CFG_WR, 32'h0009_0801, ACT_IGNORE);
		bus_cyc(CMD_CFG_WR, 32'h0009_fe01, ACT_IGNORE);
		bus_cyc(CMD_CFG_WR, 32'h0009_f701, ACT_IGNORE);
		bus_cyc(CMD_CFG_WR, 32'h0001_ff01, ACT_SPECIAL);
		bus_cyc(CMD_CFG_WR, 32'h0002_ff01, ACT_TYPE1);
		bus_cyc(CMD_CFG_WR, 32'h0006_ff01, ACT_TYPE1);
		bus_cyc(CMD_CFG_WR, 32'h0003_ff01, ACT_IGNORE);
		bus_cyc(CMD_CFG_WR, 32'h0005_ff01, ACT_IGNORE);
		bus_cyc(CMD_SPECIAL, 32'h0001_ff01, ACT_IGNORE);
		bus_cyc(4'ha, 32'h0001_ff01, ACT_IGNORE);
	endtask

	// primary number moved inside the secondary range
	task automatic t_priority();
		cfg_wr(FN_SET1, DW_BUSNUM, 4'h1, 32'h0000_0004);
		cfg_rd(FN_SET2, DW_BUSNUM, 32'h0008_0604, 1'b0);
		bus_cyc(CMD_CFG_WR, 32'h0004_ff01, ACT_SPECIAL);
		bus_cyc(CMD_CFG_WR, 32'h0001_ff01, ACT_TYPE1);
	endtask

	// reset, then the scenarios in turn
	initial
	begin
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (5) @(posedge sys_clk);
		t_reset_vals();
		t_sets();
		t_decode();
		t_priority();
		complete_run();
	end
endmodule // scc_claim_tb

`default_nettype wire
